// file: hdl/lpmc_top.sv
`timescale 1ns/100ps
module lpmc_top (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // analog supervisors, active while supply is low, and the option bit that disables analog supervision
  input wire logic digital_supply_low_in,
  input wire logic analog_supply_low_in,
  input wire logic analog_supervise_disable_in,
  input wire logic detector_below_in,
  // detector configuration
  input wire logic detector_enable_in,
  input wire logic detector_irq_fall_in,
  input wire logic detector_irq_rise_in,
  input wire logic detector_irq_clear_in,
  // core request
  input wire logic wait_in,
  input wire logic deep_sleep_in,
  input wire logic deep_is_standby_in,
  input wire logic stop_low_power_reg_in,
  input wire logic core_irq_in,
  // wake sources
  input wire logic [lpmc_pkg::LPMC_EXT_LINES-1:0] ext_lines_in,
  input wire logic rtc_event_in,
  input wire logic serial_port_one_event_in,
  input wire logic i2c_port_one_event_in,
  input wire logic [1:0] analog_comparators_in,
  input wire logic cec_event_in,
  input wire logic [lpmc_pkg::LPMC_WAKE_PINS-1:0] wakeup_pin_in,
  input wire logic external_reset_pin_n_in,
  input wire logic independent_watchdog_reset_in,
  // fast oscillator requests from peripherals
  input wire logic fast_osc_req_in,
  // outputs
  output lpmc_pkg::lpmc_power_t power_out,
  output lpmc_pkg::lpmc_status_t status_out,
  output logic always_on_clk_en_out,
  output lpmc_pkg::lpmc_state_t mode_out
);

  // ********************
  // input synchronisers
  // ********************
  // every pin listed in raw crosses in one bundle, so all of them see the same two-cycle delay
  localparam int NSYNC = 8 + lpmc_pkg::LPMC_EXT_LINES + 2 + lpmc_pkg::LPMC_WAKE_PINS + 3;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic [lpmc_pkg::LPMC_EXT_LINES-1:0] ext_s;
  logic [lpmc_pkg::LPMC_WAKE_PINS-1:0] pin_s;
  logic [1:0] cmp_s;
  logic dig_low_s;
  logic ana_low_s;
  logic det_below_s;
  logic rtc_s;
  logic ser_s;
  logic i2c_s;
  logic cec_s;
  logic ext_rst_s;
  logic wdg_s;
  logic osc_req_s;
  logic ana_dis_s;

  // the reset pin is inverted ahead of the synchroniser so its reset value means no request
  assign raw = {
    // supply supervisors
    digital_supply_low_in,
    analog_supply_low_in,
    detector_below_in,
    // single wake lines
    rtc_event_in,
    serial_port_one_event_in,
    i2c_port_one_event_in,
    cec_event_in,
    ~external_reset_pin_n_in,
    // wake vectors
    ext_lines_in,
    analog_comparators_in,
    wakeup_pin_in,
    // watchdog, oscillator request and option bit
    independent_watchdog_reset_in,
    fast_osc_req_in,
    analog_supervise_disable_in
  };

  lpmc_sync #(.WIDTH(NSYNC)) u_sync (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(raw),
    .sync_out(syn)
  );

  assign {dig_low_s, ana_low_s, det_below_s, rtc_s, ser_s, i2c_s, cec_s, ext_rst_s,
          ext_s, cmp_s, pin_s,
          wdg_s, osc_req_s, ana_dis_s} = syn;

  // ********************
  // supply-fall reset
  // ********************
  logic supply_reset;
  // left combinational so the reset request does not wait another register stage
  // analog supervision can be removed by the option bit
  assign supply_reset = dig_low_s | (ana_low_s & ~ana_dis_s);

  // ********************
  // edge detection
  // ********************
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  logic det_prev_r;
  logic det_prev_nxt;
  logic [lpmc_pkg::LPMC_WAKE_PINS-1:0] pin_prev_r;
  logic [lpmc_pkg::LPMC_WAKE_PINS-1:0] pin_prev_nxt;
  logic [lpmc_pkg::LPMC_WAKE_PINS-1:0] pin_rise;

  genvar gi;
  generate
    for (gi = 0; gi < lpmc_pkg::LPMC_WAKE_PINS; gi++) begin : g_pin
      assign pin_rise[gi] = rise(pin_s[gi], pin_prev_r[gi]);
    end
  endgenerate

  // ********************
  // programmable supply detector
  // ********************
  logic det_irq_r;
  logic det_irq_nxt;
  logic det_fall;
  logic det_rise;

  // edges come from the synchronised level: a dip shorter than a clock may be missed
  assign det_fall = rise(det_below_s, det_prev_r);
  assign det_rise = rise(det_prev_r, det_below_s);

  always_comb begin
    det_prev_nxt = det_below_s;
    pin_prev_nxt = pin_s;
    det_irq_nxt = det_irq_r;
    // a clear on its own lowers the flag one cycle later
    if (detector_irq_clear_in) begin
      det_irq_nxt = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (detector_enable_in && ((det_fall && detector_irq_fall_in) ||
        (det_rise && detector_irq_rise_in))) begin
      det_irq_nxt = 1'b1;
    end
    if (!detector_enable_in) begin
      det_irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      det_prev_r <= 1'b0;
      pin_prev_r <= '0;
      det_irq_r <= 1'b0;
    end else begin
      det_prev_r <= det_prev_nxt;
      pin_prev_r <= pin_prev_nxt;
      det_irq_r <= det_irq_nxt;
    end
  end

  // ********************
  // wake sources
  // ********************
  logic stop_wake;
  logic standby_wake;
  // detector output is one of the extended event lines, but only once it is enabled
  // levels, not edges: a source that stays high keeps the sequencer out of stop
  assign stop_wake = (|ext_s) | (det_below_s & detector_enable_in) | rtc_s | ser_s | i2c_s |
                     (|cmp_s) | cec_s;
  assign standby_wake = ext_rst_s | wdg_s | (|pin_rise) | rtc_s;

  // ********************
  // mode sequencer
  // ********************
  lpmc_pkg::lpmc_state_t state_r;
  lpmc_pkg::lpmc_state_t state_nxt;
  lpmc_pkg::lpmc_power_t power_r;
  lpmc_pkg::lpmc_power_t power_nxt;
  logic [3:0] settle_r;
  logic [3:0] settle_nxt;
  logic grant_r;
  logic grant_nxt;
  logic lp_sel_r;
  logic lp_sel_nxt;

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    lp_sel_nxt = lp_sel_r;
    grant_nxt = 1'b0;
    power_nxt = lpmc_pkg::LPMC_POWER_RUN;
    case (state_r)
      lpmc_pkg::LPMC_RUN: begin
        if (wait_in && !core_irq_in) begin
          // sleep and standby gate at the same edge as the mode changes
          if (!deep_sleep_in) begin
            state_nxt = lpmc_pkg::LPMC_SLEEP;
            power_nxt.core_clk_en = 1'b0;
          end else if (deep_is_standby_in) begin
            state_nxt = lpmc_pkg::LPMC_STANDBY;
            power_nxt = '0;
          end else begin
            state_nxt = lpmc_pkg::LPMC_STOP_ENTER;
            // latched here so a late change of the bit cannot disturb a running stop
            lp_sel_nxt = stop_low_power_reg_in;
          end
        end
      end
      lpmc_pkg::LPMC_SLEEP: begin
        power_nxt.core_clk_en = 1'b0;
        if (core_irq_in || stop_wake) begin
          state_nxt = lpmc_pkg::LPMC_RUN;
          power_nxt.core_clk_en = 1'b1;
        end
      end
      lpmc_pkg::LPMC_STOP_ENTER, lpmc_pkg::LPMC_STOP: begin
        // all core-domain clocks and fast oscillators halt except a fast oscillator a peripheral requests, state retained
        power_nxt.core_clk_en = 1'b0;
        power_nxt.periph_clk_en = 1'b0;
        power_nxt.pll_en = 1'b0;
        power_nxt.fast_osc_en = 1'b0;
        power_nxt.crystal_osc_en = 1'b0;
        power_nxt.low_power_regulator_mode = lp_sel_r;
        state_nxt = lpmc_pkg::LPMC_STOP;
        if (stop_wake) begin
          state_nxt = lpmc_pkg::LPMC_STOP_WAKE;
          settle_nxt = lpmc_pkg::LPMC_SETTLE_INIT;
        end else if (osc_req_s) begin
          // regulator returns to normal before the clock goes out
          power_nxt.low_power_regulator_mode = 1'b0;
          // the grant waits until the registered regulator mode reads normal, one cycle if it was low-power, so the clock never meets a low-power supply
          if (!power_r.low_power_regulator_mode) begin
            power_nxt.fast_osc_en = 1'b1;
            grant_nxt = 1'b1;
          end
        end
      end
      lpmc_pkg::LPMC_STOP_WAKE: begin
        // core and peripheral clocks only return once the regulator has settled in main mode; PLL and oscillators restart at once
        power_nxt.core_clk_en = 1'b0;
        power_nxt.periph_clk_en = 1'b0;
        // holds at zero so the counter never wraps
        if (settle_r != 4'h0) begin
          settle_nxt = settle_r - 4'h1;
        end
        if (settle_r == 4'h0) begin
          state_nxt = lpmc_pkg::LPMC_RUN;
          power_nxt = lpmc_pkg::LPMC_POWER_RUN;
        end
      end
      lpmc_pkg::LPMC_STANDBY: begin
        // held at zero for the whole stay; only the wake logic stays powered
        power_nxt = '0;
        if (standby_wake) begin
          // leaving standby is a full restart of the core domain
          state_nxt = lpmc_pkg::LPMC_RUN;
          power_nxt = lpmc_pkg::LPMC_POWER_RUN;
        end
      end
      default: begin
        state_nxt = lpmc_pkg::LPMC_RUN;
      end
    endcase
    if (supply_reset) begin
      state_nxt = lpmc_pkg::LPMC_RUN;
      power_nxt = lpmc_pkg::LPMC_POWER_RUN;
      grant_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= lpmc_pkg::LPMC_RUN;
      power_r <= lpmc_pkg::LPMC_POWER_RUN;
      settle_r <= 4'h0;
      grant_r <= 1'b0;
      lp_sel_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      power_r <= power_nxt;
      settle_r <= settle_nxt;
      grant_r <= grant_nxt;
      lp_sel_r <= lp_sel_nxt;
    end
  end

  // ********************
  // outputs
  // ********************
  assign power_out = power_r;
  assign status_out = '{grant_r, supply_reset, det_irq_r};
  assign always_on_clk_en_out = 1'b1;
  // straight from the state register, so a watcher never sees a decode glitch
  assign mode_out = state_r;

endmodule

// file: hdl/lpmc_pkg.sv
package lpmc_pkg;

  // ********************
  // mode encodings
  // ********************
  typedef enum {
    LPMC_RUN,
    LPMC_SLEEP,
    LPMC_STOP_ENTER,
    LPMC_STOP,
    LPMC_STOP_WAKE,
    LPMC_STANDBY
  } lpmc_state_t;

  // ********************
  // widths and timing
  // ********************
  localparam int LPMC_EXT_LINES = 16;
  localparam int LPMC_WAKE_PINS = 2;
  localparam int LPMC_EVT_LINES = 23;
  localparam int LPMC_CLK_MHZ = 100;
  localparam int LPMC_REG_SETTLE_NS = 100;
  localparam int LPMC_REG_SETTLE_CYC = (LPMC_REG_SETTLE_NS * LPMC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] LPMC_SETTLE_INIT = 4'(LPMC_REG_SETTLE_CYC);

  // ********************
  // carriers
  // ********************
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic pll_en;
    logic fast_osc_en;
    logic crystal_osc_en;
    logic regulator_on;
    logic low_power_regulator_mode;
    logic core_domain_retain;
  } lpmc_power_t;

  typedef struct packed {
    logic fast_osc_grant;
    logic supply_reset;
    logic detector_irq;
  } lpmc_status_t;

  localparam lpmc_power_t LPMC_POWER_RUN = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

endpackage

// file: hdl/lpmc_sync.sv
`timescale 1ns/100ps
module lpmc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ********************
  // two-stage synchroniser
  // ********************
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// file: tb/lpmc_core_model.sv
`timescale 1ns/100ps
module lpmc_core_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // bench command
  input wire logic cmd_in,
  input wire logic deep_in,
  input wire logic standby_in,
  // core request lines
  output logic wait_out,
  output logic deep_sleep_out,
  output logic deep_is_standby_out
);
  // wait is a one-cycle pulse, selects move with it so they are valid at the take edge
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_out <= 1'b0;
      deep_sleep_out <= 1'b0;
      deep_is_standby_out <= 1'b0;
    end else begin
      wait_out <= cmd_in;
      deep_sleep_out <= deep_in;
      deep_is_standby_out <= standby_in;
    end
  end
endmodule

// file: tb/lpmc_checker.sv
`timescale 1ns/100ps
module lpmc_checker (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // watched inputs
  input wire logic digital_supply_low_in,
  input wire logic analog_supply_low_in,
  input wire logic detector_enable_in,
  input wire logic wait_in,
  input wire logic deep_sleep_in,
  input wire logic core_irq_in,
  input wire logic rtc_event_in,
  input wire logic external_reset_pin_n_in,
  // watched outputs
  input lpmc_pkg::lpmc_power_t power_out,
  input lpmc_pkg::lpmc_status_t status_out,
  input wire logic always_on_clk_en_out,
  input lpmc_pkg::lpmc_state_t mode_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  supply_hold_a: assert property (
    status_out.supply_reset |=> power_out == lpmc_pkg::LPMC_POWER_RUN)
    else $error("power not forced to run under supply reset");
  supply_cause_a: assert property (
    status_out.supply_reset |->
    $past(digital_supply_low_in, 2) || $past(analog_supply_low_in, 2))
    else $error("supply reset without low supply");
  det_off_a: assert property (
    !detector_enable_in |=> !status_out.detector_irq)
    else $error("detector irq while disabled");
  reg_main_a: assert property (
    mode_out == lpmc_pkg::LPMC_RUN |->
    power_out.regulator_on && !power_out.low_power_regulator_mode)
    else $error("regulator not main in run");
  standby_off_a: assert property (
    mode_out == lpmc_pkg::LPMC_STANDBY |-> !power_out.regulator_on
    && !power_out.pll_en && !power_out.fast_osc_en && !power_out.crystal_osc_en
    && !power_out.core_domain_retain)
    else $error("standby left something powered");
  sleep_clk_a: assert property (
    mode_out == lpmc_pkg::LPMC_SLEEP |->
    !power_out.core_clk_en && power_out.periph_clk_en)
    else $error("sleep clock gating wrong");
  sleep_take_a: assert property (
    mode_out == lpmc_pkg::LPMC_RUN && wait_in && !core_irq_in
    && !deep_sleep_in && !status_out.supply_reset |=> mode_out == lpmc_pkg::LPMC_SLEEP)
    else $error("wait not taken into sleep");
  stop_halt_a: assert property (
    mode_out == lpmc_pkg::LPMC_STOP && !status_out.fast_osc_grant
    |-> !power_out.core_clk_en && !power_out.periph_clk_en && !power_out.pll_en
    && !power_out.fast_osc_en && !power_out.crystal_osc_en && power_out.core_domain_retain)
    else $error("stop clocks or retention wrong");
  stop_wake_a: assert property (
    mode_out == lpmc_pkg::LPMC_STOP && rtc_event_in
    |-> ##[1:4] mode_out == lpmc_pkg::LPMC_STOP_WAKE)
    else $error("no wake from stop");
  osc_order_a: assert property (
    mode_out == lpmc_pkg::LPMC_STOP && $rose(power_out.fast_osc_en)
    |-> !$past(power_out.low_power_regulator_mode))
    else $error("oscillator before regulator normal");
  grant_main_a: assert property (
    status_out.fast_osc_grant |-> power_out.fast_osc_en && !power_out.low_power_regulator_mode)
    else $error("oscillator granted on low-power regulator");
  standby_exit_a: assert property (
    mode_out == lpmc_pkg::LPMC_STANDBY && !external_reset_pin_n_in
    |-> ##[1:5] mode_out == lpmc_pkg::LPMC_RUN)
    else $error("no exit from standby");
  always_on_a: assert property (
    always_on_clk_en_out)
    else $error("always-on clocks stopped");
endmodule
bind lpmc_top lpmc_checker lpmc_checker_i (.clock_in, .rstn_in, .digital_supply_low_in,
  .analog_supply_low_in, .detector_enable_in, .wait_in, .deep_sleep_in, .core_irq_in,
  .rtc_event_in, .external_reset_pin_n_in, .power_out, .status_out, .always_on_clk_en_out,
  .mode_out);

// file: tb/tb_lpmc_top.sv
`timescale 1ns/100ps
module tb_lpmc_top;
  logic clock_in = 1'b0, rstn_in = 1'b0;
  logic digital_supply_low_in = 0, analog_supply_low_in = 0, analog_supervise_disable_in = 0;
  logic detector_below_in = 0, detector_enable_in = 0, detector_irq_fall_in = 0;
  logic detector_irq_rise_in = 0, detector_irq_clear_in = 0, stop_low_power_reg_in = 0;
  logic core_irq_in = 0, fast_osc_req_in = 0, cmd = 0, cmd_deep = 0, cmd_sb = 0;
  logic [21:0] wk = '0;
  logic [4:0] sb = '0;
  logic wait_in, deep_sleep_in, deep_is_standby_in, always_on_clk_en_out;
  logic [15:0] ext_lines_in;
  logic [1:0] analog_comparators_in, wakeup_pin_in;
  logic rtc_event_in, serial_port_one_event_in, i2c_port_one_event_in, cec_event_in;
  logic external_reset_pin_n_in, independent_watchdog_reset_in;
  lpmc_pkg::lpmc_power_t power_out;
  lpmc_pkg::lpmc_status_t status_out;
  lpmc_pkg::lpmc_state_t mode_out, last_mode, exp_q[$];
  int n_fail = 0, num_checks = 0, cyc = 0, k, b;
  // wake sources packed so one loop index can select any of them
  assign ext_lines_in = wk[15:0];
  assign rtc_event_in = wk[16] | sb[4];
  assign serial_port_one_event_in = wk[17];
  assign i2c_port_one_event_in = wk[18];
  assign analog_comparators_in = wk[20:19];
  assign cec_event_in = wk[21];
  assign external_reset_pin_n_in = ~sb[0];
  assign independent_watchdog_reset_in = sb[1];
  assign wakeup_pin_in = sb[3:2];
  lpmc_top lpmc_top_i (.*);
  lpmc_core_model lpmc_core_model_i (.clock_in(clock_in), .rstn_in(rstn_in), .cmd_in(cmd),
    .deep_in(cmd_deep), .standby_in(cmd_sb), .wait_out(wait_in),
    .deep_sleep_out(deep_sleep_in), .deep_is_standby_out(deep_is_standby_in));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic deep, input logic stby);
    @(posedge clock_in);
    cmd <= 1'b1;
    cmd_deep <= deep;
    cmd_sb <= stby;
    @(posedge clock_in);
    cmd <= 1'b0;
  endtask
  task automatic wait_mode(input lpmc_pkg::lpmc_state_t m);
    for (int i = 0; i < 60 && mode_out !== m; i++) @(posedge clock_in);
  endtask
  task automatic push_stop();
    exp_q.push_back(lpmc_pkg::LPMC_STOP_ENTER);
    exp_q.push_back(lpmc_pkg::LPMC_STOP);
    exp_q.push_back(lpmc_pkg::LPMC_STOP_WAKE);
    exp_q.push_back(lpmc_pkg::LPMC_RUN);
  endtask
  // every mode change must match the oldest noted expectation
  always @(negedge clock_in) begin
    if (rstn_in && mode_out !== last_mode) begin
      if (exp_q.size() == 0) chk(mode_out, last_mode);
      else chk(mode_out, exp_q.pop_front());
    end
    last_mode = mode_out;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    last_mode = lpmc_pkg::LPMC_RUN;
    void'($urandom(97450));
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(negedge clock_in);
    chk(power_out, lpmc_pkg::LPMC_POWER_RUN);
    chk(always_on_clk_en_out, 1);
    exp_q.push_back(lpmc_pkg::LPMC_SLEEP);
    exp_q.push_back(lpmc_pkg::LPMC_RUN);
    req(0, 0);
    wait_mode(lpmc_pkg::LPMC_SLEEP);
    chk(power_out.core_clk_en, 0);
    chk(power_out.periph_clk_en, 1);
    core_irq_in <= 1'b1;
    wait_mode(lpmc_pkg::LPMC_RUN);
    req(0, 0);
    repeat (4) @(posedge clock_in);
    core_irq_in <= 1'b0;
    for (k = 0; k < 8; k++) begin
      b = (k == 0) ? $urandom_range(15) : 15 + k;
      stop_low_power_reg_in <= (k == 7) ? 1'b1 : 1'($urandom_range(1));
      push_stop();
      req(1, 0);
      wait_mode(lpmc_pkg::LPMC_STOP);
      chk(power_out.pll_en, 0);
      chk(power_out.core_domain_retain, 1);
      if (k == 7) begin
        chk(power_out.low_power_regulator_mode, 1);
        b = 0;
        fast_osc_req_in <= 1'b1;
        for (int i = 0; i < 20 && power_out.fast_osc_en !== 1'b1; i++) @(posedge clock_in);
        chk(power_out.low_power_regulator_mode, 0);
        chk(status_out.fast_osc_grant, 1);
        fast_osc_req_in <= 1'b0;
      end
      wk[b] <= 1'b1;
      wait_mode(lpmc_pkg::LPMC_RUN);
      wk[b] <= 1'b0;
    end
    for (k = 0; k < 5; k++) begin
      exp_q.push_back(lpmc_pkg::LPMC_STANDBY);
      exp_q.push_back(lpmc_pkg::LPMC_RUN);
      req(1, 1);
      wait_mode(lpmc_pkg::LPMC_STANDBY);
      @(negedge clock_in);
      chk(power_out.regulator_on, 0);
      chk(power_out.core_domain_retain, 0);
      @(posedge clock_in);
      sb[k] <= 1'b1;
      wait_mode(lpmc_pkg::LPMC_RUN);
      sb[k] <= 1'b0;
    end
    for (k = 0; k < 3; k++) begin
      digital_supply_low_in <= (k == 0);
      analog_supply_low_in <= (k != 0);
      analog_supervise_disable_in <= (k == 2);
      repeat (5) @(posedge clock_in);
      chk(status_out.supply_reset, k != 2);
    end
    analog_supply_low_in <= 1'b0;
    detector_enable_in <= 1'b1;
    detector_irq_fall_in <= 1'b1;
    @(posedge clock_in);
    detector_below_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    chk(status_out.detector_irq, 1);
    detector_enable_in <= 1'b0;
    detector_irq_fall_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk(status_out.detector_irq, 0);
    detector_enable_in <= 1'b1;
    detector_irq_rise_in <= 1'b1;
    @(posedge clock_in);
    detector_below_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    chk(status_out.detector_irq, 1);
    detector_irq_clear_in <= 1'b1;
    @(posedge clock_in);
    detector_irq_clear_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk(status_out.detector_irq, 0);
    chk(exp_q.size(), 0);
    print_verdict();
  end
endmodule
